// File: rtl/pfr_consts.vh
// Contract
// - Page value read returns addressed page register
// - Page address advances after each value access
// - Long count limit 16-bit at 54h/55h, zero
// - Long counter reaching limit raises interrupt
// - Program base at 58h/59h; host keeps >=19Ch
// - Carry-count bit: step interrupt only on overflow
// - False-step filter needs a learning-core enable
// - Steps counted only after debounce threshold reached
// - Step delta period 16-bit, 2.56 ms per count
// - Gain word is half-precision: sign, exponent, fraction
// - Gain scales samples for both engines
// - Duration threshold is ODR period times field/16
// - Window count is sixteen times low field
// - Page 0 only with selector 0 and functions on
`ifndef PFR_CONSTS_VH
`define PFR_CONSTS_VH
`define PFR_BANK_GATE_BIT 7
`define PFR_PAGE_READ_BIT 5
`define PFR_PAGE_WRITE_BIT 6
`define PFR_ADDR_PAGE_ADDRESS 8'h08
`define PFR_ADDR_PAGE_VALUE 8'h09
`define PFR_OFS_LCL_LO 8'h54
`define PFR_OFS_LCL_HI 8'h55
`define PFR_OFS_PROG_CNT 8'h56
`define PFR_OFS_BASE_LO 8'h58
`define PFR_OFS_BASE_HI 8'h59
`define PFR_OFS_STEP_CMD 8'h5d
`define PFR_OFS_DEBOUNCE 8'h5e
`define PFR_OFS_DELTA_LO 8'haa
`define PFR_OFS_DELTA_HI 8'hab
`define PFR_OFS_GAIN_LO 8'hb6
`define PFR_OFS_GAIN_HI 8'hb7
`define PFR_OFS_POWER 8'hd2
`define PFR_RST_ZERO 8'h00
`define PFR_RST_DEBOUNCE 8'h0a
`define PFR_RST_GAIN_LO 8'h66
`define PFR_RST_GAIN_HI 8'h12
`define PFR_CARRY_BIT 3
`define PFR_FILTER_BIT 2
`define PFR_CMD_USED_MASK 8'h0c
`define PFR_DELTA_UNIT_NS 2560000
`define PFR_CLK_PERIOD_NS 4
`define PFR_DELTA_UNIT_CYC (`PFR_DELTA_UNIT_NS / `PFR_CLK_PERIOD_NS)
`define PFR_WIN_SCALE 16
`endif

// File: rtl/pfr_half_scale.v
`timescale 1ns/1ps
`include "pfr_consts.vh"
// Multiplies a signed sample by a half-precision gain word
module pfr_half_scale #(
  parameter SAMPLE_W = 16
) (
  input wire clk_in,
  input wire rstn_in,
  input wire [15:0] gain_in,
  input wire [SAMPLE_W-1:0] sample_in,
  input wire sample_valid_in,
  output reg [SAMPLE_W-1:0] scaled_out,
  output reg scaled_valid_out
);
  // Field split, sign first
  wire gain_sign = gain_in[15];
  wire [4:0] gain_exp = gain_in[14:10];
  wire [9:0] gain_frac = gain_in[9:0];
  // Mantissa with hidden one unless subnormal
  wire [10:0] mant = {(gain_exp != 5'd0), gain_frac};
  wire signed [SAMPLE_W+11:0] prod = $signed(sample_in) * $signed({1'b0, mant});
  reg signed [SAMPLE_W+11:0] shifted;
  // Shift by exponent minus bias and fraction width
  always @* begin
    if (gain_exp == 5'd0) begin
      shifted = prod >>> 24;
    end else if (gain_exp >= 5'd25) begin
      shifted = prod <<< (gain_exp - 5'd25);
    end else begin
      shifted = prod >>> (5'd25 - gain_exp);
    end
  end
  // Registered result with sign applied
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      scaled_out <= {SAMPLE_W{1'b0}};
      scaled_valid_out <= 1'b0;
    end else begin
      scaled_valid_out <= sample_valid_in;
      if (gain_sign) begin
        scaled_out <= -shifted[SAMPLE_W-1:0];
      end else begin
        scaled_out <= shifted[SAMPLE_W-1:0];
      end
    end
  end
endmodule // pfr_half_scale

// File: rtl/pfr_step_gate.v
`timescale 1ns/1ps
`include "pfr_consts.vh"
// Debounced step counter with interrupt policy
module pfr_step_gate #(
  parameter COUNT_W = 16
) (
  input wire clk_in,
  input wire rstn_in,
  input wire step_in,
  input wire [7:0] debounce_in,
  input wire carry_only_in,
  input wire filter_on_in,
  input wire false_step_in,
  output reg [COUNT_W-1:0] count_out,
  output reg step_irq_out
);
  reg [7:0] seen;
  wire armed = (seen >= debounce_in);
  wire accept = step_in && !(filter_on_in && false_step_in);
  // Count detected steps, then count once debounce reached
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      seen <= 8'h00;
      count_out <= {COUNT_W{1'b0}};
      step_irq_out <= 1'b0;
    end else begin
      step_irq_out <= 1'b0;
      if (accept) begin
        if (!armed) begin
          seen <= seen + 8'h01;
        end
        if (armed || (seen + 8'h01 >= debounce_in)) begin
          count_out <= count_out + 1'b1;
          if (carry_only_in) begin
            step_irq_out <= &count_out;
          end else begin
            step_irq_out <= 1'b1;
          end
        end
      end
    end
  end
endmodule // pfr_step_gate

// File: rtl/pfr_bank.v
`timescale 1ns/1ps
`include "pfr_consts.vh"
// Page-0 indirect register bank of the embedded functions
module pfr_bank #(
  parameter SAMPLE_W = 16,
  parameter DELTA_UNIT_CYC = `PFR_DELTA_UNIT_CYC
) (
  input wire clk_in,
  input wire rstn_in,
  input wire main_wr_in,
  input wire main_rd_in,
  input wire [7:0] main_addr_in,
  input wire [7:0] main_wdata_in,
  input wire bank_gate_bit_in,
  input wire page_read_in,
  input wire page_write_in,
  input wire [3:0] page_select_in,
  input wire onchip_functions_on_in,
  input wire learning_core_on_in,
  input wire learning_core_first_on_in,
  input wire [15:0] long_counter_in,
  input wire step_in,
  input wire false_step_in,
  input wire [SAMPLE_W-1:0] bio_sample_in,
  input wire bio_valid_in,
  input wire [15:0] odr_period_in,
  output reg [7:0] page_value_out,
  output reg [7:0] page_address_out,
  output reg fsm_irq_out,
  output reg step_irq_out,
  output reg [15:0] step_count_out,
  output reg delta_tick_out,
  output reg [15:0] program_base_address_out,
  output reg [7:0] program_total_out,
  output reg [SAMPLE_W-1:0] bio_scaled_out,
  output reg bio_scaled_valid_out,
  output reg [19:0] power_saver_duration_out,
  output reg [7:0] power_saver_windows_out
);
  // Main-map addresses of the window registers
  localparam [7:0] ADDR_PAGE_ADDRESS = `PFR_ADDR_PAGE_ADDRESS;
  localparam [7:0] ADDR_PAGE_VALUE = `PFR_ADDR_PAGE_VALUE;

  reg [7:0] fsm_long_count_limit_lo;
  reg [7:0] fsm_long_count_limit_hi;
  reg [7:0] fsm_program_count;
  reg [7:0] fsm_program_base_lo;
  reg [7:0] fsm_program_base_hi;
  reg [7:0] step_algo_command;
  reg [7:0] step_debounce_threshold;
  reg [7:0] step_delta_period_lo;
  reg [7:0] step_delta_period_hi;
  reg [7:0] biopotential_gain_lo;
  reg [7:0] biopotential_gain_hi;
  reg [7:0] power_saver_timing;
  reg [7:0] page_addr;
  reg [31:0] delta_cyc;
  reg [15:0] delta_units;
  reg limit_hit_d;

  // Read-back mux for a page-0 offset
  function [7:0] pfr_read;
    input [7:0] ofs;
    begin
      case (ofs)
        `PFR_OFS_LCL_LO: pfr_read = fsm_long_count_limit_lo;
        `PFR_OFS_LCL_HI: pfr_read = fsm_long_count_limit_hi;
        `PFR_OFS_PROG_CNT: pfr_read = fsm_program_count;
        `PFR_OFS_BASE_LO: pfr_read = fsm_program_base_lo;
        `PFR_OFS_BASE_HI: pfr_read = fsm_program_base_hi;
        `PFR_OFS_STEP_CMD: pfr_read = step_algo_command;
        `PFR_OFS_DEBOUNCE: pfr_read = step_debounce_threshold;
        `PFR_OFS_DELTA_LO: pfr_read = step_delta_period_lo;
        `PFR_OFS_DELTA_HI: pfr_read = step_delta_period_hi;
        `PFR_OFS_GAIN_LO: pfr_read = biopotential_gain_lo;
        `PFR_OFS_GAIN_HI: pfr_read = biopotential_gain_hi;
        `PFR_OFS_POWER: pfr_read = power_saver_timing;
        default: pfr_read = 8'h00;
      endcase
    end
  endfunction

  // Page 0 open only with gate, selector 0 and functions on
  wire page_open = bank_gate_bit_in && onchip_functions_on_in
    && (page_select_in == 4'h0);
  wire value_wr = page_open && page_write_in && main_wr_in
    && (main_addr_in == ADDR_PAGE_VALUE);
  wire value_rd = page_open && page_read_in && main_rd_in
    && (main_addr_in == ADDR_PAGE_VALUE);
  wire addr_wr = bank_gate_bit_in && main_wr_in && (main_addr_in == ADDR_PAGE_ADDRESS);

  // Page address register, auto-increment after value access
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      page_addr <= 8'h00;
    end else if (addr_wr) begin
      page_addr <= main_wdata_in;
    end else if (value_wr || value_rd) begin
      page_addr <= page_addr + 8'h01;
    end
  end

  // Page-0 storage with documented defaults
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      fsm_long_count_limit_lo <= `PFR_RST_ZERO;
      fsm_long_count_limit_hi <= `PFR_RST_ZERO;
      fsm_program_count <= `PFR_RST_ZERO;
      fsm_program_base_lo <= `PFR_RST_ZERO;
      fsm_program_base_hi <= `PFR_RST_ZERO;
      step_algo_command <= `PFR_RST_ZERO;
      step_debounce_threshold <= `PFR_RST_DEBOUNCE;
      step_delta_period_lo <= `PFR_RST_ZERO;
      step_delta_period_hi <= `PFR_RST_ZERO;
      biopotential_gain_lo <= `PFR_RST_GAIN_LO;
      biopotential_gain_hi <= `PFR_RST_GAIN_HI;
      power_saver_timing <= `PFR_RST_ZERO;
    end else if (value_wr) begin
      case (page_addr)
        `PFR_OFS_LCL_LO: fsm_long_count_limit_lo <= main_wdata_in;
        `PFR_OFS_LCL_HI: fsm_long_count_limit_hi <= main_wdata_in;
        `PFR_OFS_PROG_CNT: fsm_program_count <= main_wdata_in;
        `PFR_OFS_BASE_LO: fsm_program_base_lo <= main_wdata_in;
        `PFR_OFS_BASE_HI: fsm_program_base_hi <= main_wdata_in;
        `PFR_OFS_STEP_CMD: step_algo_command <= main_wdata_in & `PFR_CMD_USED_MASK;
        `PFR_OFS_DEBOUNCE: step_debounce_threshold <= main_wdata_in;
        `PFR_OFS_DELTA_LO: step_delta_period_lo <= main_wdata_in;
        `PFR_OFS_DELTA_HI: step_delta_period_hi <= main_wdata_in;
        `PFR_OFS_GAIN_LO: biopotential_gain_lo <= main_wdata_in;
        `PFR_OFS_GAIN_HI: biopotential_gain_hi <= main_wdata_in;
        `PFR_OFS_POWER: power_saver_timing <= main_wdata_in;
        default: ;
      endcase
    end
  end

  // Page value window output, latched on each value read
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      page_value_out <= 8'h00;
      page_address_out <= 8'h00;
    end else begin
      page_address_out <= page_addr;
      if (value_rd) begin
        page_value_out <= pfr_read(page_addr);
      end
    end
  end

  // Long-counter limit interrupt on reaching the value
  wire limit_hit = onchip_functions_on_in
    && (long_counter_in == {fsm_long_count_limit_hi, fsm_long_count_limit_lo});
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      limit_hit_d <= 1'b0;
      fsm_irq_out <= 1'b0;
    end else begin
      limit_hit_d <= limit_hit;
      fsm_irq_out <= limit_hit && !limit_hit_d;
    end
  end

  // Program configuration outputs
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      program_total_out <= 8'h00;
      program_base_address_out <= 16'h0000;
    end else begin
      program_total_out <= fsm_program_count;
      program_base_address_out <= {fsm_program_base_hi, fsm_program_base_lo};
    end
  end

  // Delta-time ticks, one per programmed period of 2.56 ms units
  wire [15:0] delta_period = {step_delta_period_hi, step_delta_period_lo};
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      delta_cyc <= 32'h0000_0000;
      delta_units <= 16'h0000;
      delta_tick_out <= 1'b0;
    end else begin
      delta_tick_out <= 1'b0;
      if (delta_period == 16'h0000) begin
        delta_cyc <= 32'h0000_0000;
        delta_units <= 16'h0000;
      end else if (delta_cyc >= DELTA_UNIT_CYC - 1) begin
        delta_cyc <= 32'h0000_0000;
        if (delta_units >= delta_period - 16'h0001) begin
          delta_units <= 16'h0000;
          delta_tick_out <= 1'b1;
        end else begin
          delta_units <= delta_units + 16'h0001;
        end
      end else begin
        delta_cyc <= delta_cyc + 32'h0000_0001;
      end
    end
  end

  // Smart-power thresholds from the timing register
  wire [3:0] dur_field = power_saver_timing[7:4];
  wire [3:0] win_field = power_saver_timing[3:0];
  wire [19:0] dur_prod = odr_period_in * dur_field;
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      power_saver_duration_out <= 20'h0_0000;
      power_saver_windows_out <= 8'h00;
    end else begin
      power_saver_duration_out <= {4'h0, dur_prod[19:4]};
      power_saver_windows_out <= {win_field, 4'h0};
    end
  end

  // Step counting with debounce and interrupt policy
  wire filter_on = step_algo_command[`PFR_FILTER_BIT]
    && (learning_core_on_in || learning_core_first_on_in);
  wire [15:0] step_count;
  wire step_irq;
  pfr_step_gate #(
    .COUNT_W(16)
  ) u_step (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .step_in(step_in && onchip_functions_on_in),
    .debounce_in(step_debounce_threshold),
    .carry_only_in(step_algo_command[`PFR_CARRY_BIT]),
    .filter_on_in(filter_on),
    .false_step_in(false_step_in),
    .count_out(step_count),
    .step_irq_out(step_irq)
  );
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      step_count_out <= 16'h0000;
      step_irq_out <= 1'b0;
    end else begin
      step_count_out <= step_count;
      step_irq_out <= step_irq;
    end
  end

  // Biopotential scaling shared by both engines
  wire [SAMPLE_W-1:0] scaled;
  wire scaled_valid;
  pfr_half_scale #(
    .SAMPLE_W(SAMPLE_W)
  ) u_scale (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .gain_in({biopotential_gain_hi, biopotential_gain_lo}),
    .sample_in(bio_sample_in),
    .sample_valid_in(bio_valid_in),
    .scaled_out(scaled),
    .scaled_valid_out(scaled_valid)
  );
  always @(posedge clk_in) begin
    if (!rstn_in) begin
      bio_scaled_out <= {SAMPLE_W{1'b0}};
      bio_scaled_valid_out <= 1'b0;
    end else begin
      bio_scaled_out <= scaled;
      bio_scaled_valid_out <= scaled_valid;
    end
  end
endmodule // pfr_bank

// File: verification/pfr_host.sv
`timescale 1ns/1ps
// Host side of the page window: mode levels plus one-cycle main-map strobes
module pfr_host (
  input wire clk_in,
  input wire [7:0] value_in,
  output reg wr_out,
  output reg rd_out,
  output reg [7:0] addr_out,
  output reg [7:0] data_out,
  output reg gate_out,
  output reg rmode_out,
  output reg wmode_out,
  output reg [3:0] sel_out
);
  // Idle levels
  initial {wr_out, rd_out, addr_out, data_out, gate_out, rmode_out, wmode_out, sel_out} = 0;
  // Gate and mode are set once per procedure, held until the next call
  task mode(input g, input r, input w, input [3:0] s);
    @(posedge clk_in);
    gate_out <= g;
    rmode_out <= r;
    wmode_out <= w;
    sel_out <= s;
  endtask
  // One strobe; address and data are garbled once released
  task bus(input r, input [7:0] a, input [7:0] d, output [7:0] q);
    @(posedge clk_in);
    addr_out <= a;
    data_out <= d;
    wr_out <= !r;
    rd_out <= r;
    @(posedge clk_in);
    wr_out <= 1'b0;
    rd_out <= 1'b0;
    addr_out <= ~a;
    data_out <= ~d;
    #1 q = value_in;
  endtask
  // Address then value step of one indirect transfer
  task put(input [7:0] a, input [7:0] d);
    reg [7:0] q;
    bus(1'b0, 8'h08, a, q);
    bus(1'b0, 8'h09, d, q);
  endtask
  task get(input [7:0] a, output [7:0] q);
    bus(1'b0, 8'h08, a, q);
    bus(1'b1, 8'h09, 8'h00, q);
  endtask
endmodule // pfr_host

// File: verification/pfr_bank_sva.sv
`timescale 1ns/1ps
// Watches the page window protocol and the derived outputs
module pfr_bank_sva #(
  parameter DELTA_UNIT_CYC = 4
) (
  input wire clk_in,
  input wire rstn_in,
  input wire main_wr_in,
  input wire main_rd_in,
  input wire [7:0] main_addr_in,
  input wire [7:0] main_wdata_in,
  input wire bank_gate_bit_in,
  input wire page_read_in,
  input wire page_write_in,
  input wire [3:0] page_select_in,
  input wire onchip_functions_on_in,
  input wire step_in,
  input wire [7:0] page_value_out,
  input wire [7:0] page_address_out,
  input wire fsm_irq_out,
  input wire step_irq_out,
  input wire delta_tick_out,
  input wire [7:0] program_total_out,
  input wire [7:0] power_saver_windows_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);
  // Decoded value accesses
  wire open_pg = bank_gate_bit_in & onchip_functions_on_in & (page_select_in == 4'h0);
  wire val = main_addr_in == 8'h09;
  wire wacc = main_wr_in & val & open_pg & page_write_in;
  wire racc = main_rd_in & val & open_pg & page_read_in;
  wire refused = (main_wr_in | main_rd_in) & val & ~wacc & ~racc;
  // Written byte reaches the program total copy two edges later
  property copy_p;
    wacc && page_address_out == 8'h56 |-> ##2 program_total_out == $past(main_wdata_in, 2);
  endproperty
  // Address output trails the internal pointer by one edge
  addr_load_a: assert property (main_wr_in && main_addr_in == 8'h08 && bank_gate_bit_in
    |-> ##2 page_address_out == $past(main_wdata_in, 2)) else $error("address not loaded");
  addr_step_a: assert property (wacc || racc
    |-> ##2 page_address_out == $past(page_address_out) + 8'h01) else $error("no advance");
  closed_addr_a: assert property (refused |-> ##2 $stable(page_address_out))
    else $error("refused access moved address");
  value_hold_a: assert property (!racc |=> $stable(page_value_out))
    else $error("value changed without read");
  total_copy_a: assert property (copy_p) else $error("total not copied");
  win_scale_a: assert property (power_saver_windows_out[3:0] == 4'h0)
    else $error("windows not multiple of 16");
  lc_pulse_a: assert property (fsm_irq_out |=> !fsm_irq_out) else $error("long irq");
  tick_pulse_a: assert property ($rose(delta_tick_out) |=> $fell(delta_tick_out))
    else $error("tick too long");
  step_cause_a: assert property (step_irq_out |-> $past(step_in) || $past(step_in, 2))
    else $error("step irq without step");
  cover property (wacc ##2 wacc);
  cover property (racc ##2 racc);
  cover property (fsm_irq_out);
endmodule // pfr_bank_sva
bind pfr_bank pfr_bank_sva #(.DELTA_UNIT_CYC(DELTA_UNIT_CYC)) chk_u (
  .clk_in(clk_in), .rstn_in(rstn_in), .main_wr_in(main_wr_in), .main_rd_in(main_rd_in),
  .main_addr_in(main_addr_in), .main_wdata_in(main_wdata_in),
  .bank_gate_bit_in(bank_gate_bit_in), .page_read_in(page_read_in),
  .page_write_in(page_write_in), .page_select_in(page_select_in),
  .onchip_functions_on_in(onchip_functions_on_in), .step_in(step_in),
  .page_value_out(page_value_out), .page_address_out(page_address_out),
  .fsm_irq_out(fsm_irq_out), .step_irq_out(step_irq_out), .delta_tick_out(delta_tick_out),
  .program_total_out(program_total_out), .power_saver_windows_out(power_saver_windows_out));

// File: verification/pfr_bank_tb.sv
`timescale 1ns/1ps
// Drives the bank through the host model and checks its outputs
module pfr_bank_tb;
  reg clk_in = 0;
  reg rstn_in = 0;
  reg fon = 1, lc = 0, lcf = 0, step = 0, fstep = 0, bv = 0;
  reg [15:0] lcnt = 0, odr = 0, bs = 0, s, lim;
  wire wr, rd, gate, rm, wm, firq, sirq, tick, bvo;
  wire [3:0] sel;
  wire [7:0] ad, wd, pval, padr, ptot, pwin;
  wire [15:0] scnt, pbase, bso;
  wire [19:0] pdur;
  integer miscompares = 0, checks = 0, irqs = 0, sirqs = 0, ticks = 0, i, j, n;
  reg [31:0] rnd = 32'h0000_48de;
  reg [7:0] q;
  reg [7:0] wv [6];
  reg [7:0] ofs [13] = '{8'h54, 8'h55, 8'h56, 8'h58, 8'h59, 8'h5d, 8'h5e, 8'haa, 8'hab,
    8'hb6, 8'hb7, 8'hd2, 8'h57};
  reg [7:0] dv [13] = '{0, 0, 0, 0, 0, 0, 8'h0a, 0, 0, 8'h66, 8'h12, 0, 0};
  reg [15:0] gains [3] = '{16'h3c00, 16'h4000, 16'hbc00};
  // Clock
  initial forever #2 clk_in = ~clk_in;
  pfr_host host_u (.clk_in(clk_in), .value_in(pval), .wr_out(wr), .rd_out(rd), .addr_out(ad),
    .data_out(wd), .gate_out(gate), .rmode_out(rm), .wmode_out(wm), .sel_out(sel));
  pfr_bank #(.DELTA_UNIT_CYC(4)) dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .main_wr_in(wr),
    .main_rd_in(rd), .main_addr_in(ad), .main_wdata_in(wd), .bank_gate_bit_in(gate),
    .page_read_in(rm), .page_write_in(wm), .page_select_in(sel), .onchip_functions_on_in(fon),
    .learning_core_on_in(lc), .learning_core_first_on_in(lcf), .long_counter_in(lcnt),
    .step_in(step), .false_step_in(fstep), .bio_sample_in(bs), .bio_valid_in(bv),
    .odr_period_in(odr), .page_value_out(pval), .page_address_out(padr), .fsm_irq_out(firq),
    .step_irq_out(sirq), .step_count_out(scnt), .delta_tick_out(tick),
    .program_base_address_out(pbase), .program_total_out(ptot), .bio_scaled_out(bso),
    .bio_scaled_valid_out(bvo), .power_saver_duration_out(pdur),
    .power_saver_windows_out(pwin));
  // Event counters, sampled away from the active edge
  always @(negedge clk_in) begin
    irqs <= irqs + firq;
    sirqs <= sirqs + sirq;
    ticks <= ticks + tick;
  end
  function [31:0] lf(input [31:0] v);
    lf = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function [31:0] steps_exp(input integer k, input integer d);
    steps_exp = k >= d ? k - d + 1 : 0;
  endfunction
  function [15:0] bio_exp(input integer k, input [15:0] v);
    bio_exp = k == 0 ? v : k == 1 ? v << 1 : 16'h0000 - v;
  endfunction
  task chk(input string nm, input [31:0] seen, input [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task steps(input integer k);
    repeat (k) begin
      @(posedge clk_in) step <= 1;
      @(posedge clk_in) step <= 0;
      repeat (2) @(posedge clk_in);
    end
  endtask
  task stop_test;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog
  initial begin
    #200000;
    miscompares++;
    stop_test;
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_in);
    rstn_in <= 1;
    host_u.mode(1, 1, 0, 4'h0);
    for (i = 0; i < 13; i++) begin
      host_u.get(ofs[i], q);
      chk("default", q, dv[i]);
      repeat (2) @(negedge clk_in); // Address output lags the pointer
      chk("next addr", padr, ofs[i] + 8'h01);
    end
    $display("test defaults done");
    repeat (4) begin
      for (j = 0; j < 6; j++) begin
        rnd = lf(rnd);
        wv[j] = rnd[7:0];
      end
      wv[2] = rnd[11:8] % 9;
      wv[5] = wv[5] | 8'h02;
      host_u.mode(1, 0, 1, 4'h0);
      host_u.bus(0, 8'h08, 8'h54, q);
      for (j = 0; j < 6; j++) host_u.bus(0, 8'h09, wv[j], q);
      repeat (2) @(negedge clk_in);
      chk("burst addr", padr, 8'h5a);
      host_u.mode(1, 1, 0, 4'h0);
      host_u.bus(0, 8'h08, 8'h54, q);
      for (j = 0; j < 6; j++) begin
        host_u.bus(1, 8'h09, 8'h00, q);
        chk("readback", q, j == 3 ? 8'h00 : wv[j]);
      end
      chk("total", ptot, wv[2]);
      chk("base", pbase, {wv[5], wv[4]});
    end
    rnd = lf(rnd);
    @(posedge clk_in) odr <= rnd[15:0];
    host_u.mode(1, 0, 1, 4'h0);
    host_u.put(8'hd2, rnd[23:16]);
    host_u.put(8'h5e, 8'h03);
    chk("duration", pdur, (odr * rnd[23:20]) / 16);
    chk("windows", pwin, rnd[19:16] * 16);
    for (j = 0; j < 4; j++) begin
      @(posedge clk_in) fon <= j != 3;
      host_u.mode(j != 0, j == 2, j != 2, {3'h0, j == 1});
      host_u.bus(0, 8'h09, 8'h77, q);
      chk("closed addr", padr, 8'h5f);
    end
    @(posedge clk_in) fon <= 1;
    host_u.mode(1, 0, 1, 4'h0);
    host_u.put(8'h5e, 8'h03);
    host_u.put(8'h5d, 8'h00);
    $display("test refusal done");
    steps(2);
    chk("below debounce", scnt, steps_exp(2, 3));
    n = sirqs;
    steps(1);
    chk("at debounce", scnt, steps_exp(3, 3));
    chk("step irq", sirqs - n, 1);
    host_u.put(8'h5d, 8'h08);
    n = sirqs;
    steps(3);
    chk("carry irq", sirqs - n, 0);
    host_u.put(8'h5d, 8'h04);
    @(posedge clk_in) fstep <= 1;
    for (j = 0; j < 3; j++) begin
      @(posedge clk_in) lc <= j == 1;
      lcf <= j == 2;
      steps(2);
      chk("filter", scnt, steps_exp(8, 3));
    end
    $display("test steps done");
    rnd = lf(rnd);
    lim = rnd[15:0] | 16'h0010;
    host_u.put(8'h54, lim[7:0]);
    host_u.put(8'h55, lim[15:8]);
    n = irqs;
    for (i = 0; i < 7; i++) @(posedge clk_in) lcnt <= lim - 3 + i;
    repeat (3) @(negedge clk_in);
    chk("limit irq", irqs - n, 1);
    for (j = 1; j < 3; j++) begin
      host_u.put(8'haa, j);
      host_u.put(8'hab, 8'h00);
      @(negedge clk_in);
      n = ticks;
      repeat (40) @(negedge clk_in);
      chk("ticks", ticks - n, 40 / (4 * j));
    end
    for (j = 0; j < 3; j++) begin
      host_u.put(8'hb6, gains[j][7:0]);
      host_u.put(8'hb7, gains[j][15:8]);
      rnd = lf(rnd);
      s = {{4{rnd[11]}}, rnd[11:0]};
      @(posedge clk_in) bs <= s;
      bv <= 1;
      @(posedge clk_in) bv <= 0;
      for (i = 0; i < 20 && bvo !== 1'b1; i++) @(negedge clk_in);
      chk("bio valid", bvo, 1);
      chk("bio scaled", bso, bio_exp(j, s));
    end
    $display("test timing and gain done");
    stop_test;
  end
endmodule // pfr_bank_tb
